// ### hw/cfl_loader.sv
`timescale 1ns/1ps
// -------------------------------------------------------------
// Byte FIFO between the bitstream source and the memory writer
// -------------------------------------------------------------
module cfl_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input  wire logic         ref_clk_i,   // Core clock
   input  wire logic         nrst_i,      // Sync reset, active low
   input  wire logic         clear_i,     // Flush at load start
   input  wire logic         in_valid_i,  // Write request
   output logic              in_ready_o,  // Room left
   input  wire logic [W-1:0] in_data_i,   // Write data
   output logic              out_valid_o, // Data held
   input  wire logic         out_ready_i, // Reader takes
   output logic [W-1:0]      out_data_o   // Head word
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;   // Storage flops
      logic [AW-1:0]       wp;    // Write index
      logic [AW-1:0]       rp;    // Read index
      logic [AW:0]         cnt;   // Fill level
   } cfl_fifo_t;

   cfl_fifo_t s;
   cfl_fifo_t next_s;
   logic      wr;
   logic      rd;

   assign in_ready_o  = (s.cnt != (AW+1)'(D));
   assign out_valid_o = (s.cnt != '0);
   assign out_data_o  = s.mem[s.rp];
   assign wr          = in_valid_i && in_ready_o;
   assign rd          = out_valid_o && out_ready_i;

   // Pointer and level update
   always_comb
   begin
      next_s = s;
      if (wr)
      begin
         next_s.mem[s.wp] = in_data_i;
         next_s.wp        = (s.wp == AW'(D-1)) ? '0 : s.wp + 1'b1;
      end
      if (rd)
         next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + 1'b1;
      next_s.cnt = s.cnt + (AW+1)'(wr) - (AW+1)'(rd);
      if (clear_i)
      begin
         next_s.wp  = '0;
         next_s.rp  = '0;
         next_s.cnt = '0;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         s <= '0;
      else
         s <= next_s;
   end
endmodule

// -------------------------------------------------------------
// Configuration loader
// -------------------------------------------------------------
module cfl_loader import cfl_pkg::*; #(
   parameter int WAKE_WAIT = WAKE_WAIT_CYC,   // Wake wait in core cycles
   parameter int CFG_BYTES = 4096             // Bitstream length in bytes
) (
   input  wire logic        ref_clk_i,          // Internal oscillator, 200 MHz
   input  wire logic        nrst_i,             // Sync reset, active low
   input  wire logic        config_reset_low_i, // Load trigger pin
   input  wire logic [1:0]  mode_sel_i,         // Mode strap pins
   input  wire logic [1:0]  width_sel_i,        // Width strap pins
   output logic             spi_sclk_o,         // Flash clock
   output logic             spi_cs_n_o,         // Flash select, active low
   input  wire logic [3:0]  spi_io_i,           // Flash data in
   output logic [3:0]       spi_io_o,           // Flash data out
   output logic [3:0]       spi_io_oe_n_o,      // Drive enable, low drives
   input  wire logic        link_clk_i,         // Passive or test clock
   input  wire logic        pass_cs_n_i,        // Passive select, active low
   input  wire logic [7:0]  pass_data_i,        // Passive data
   input  wire logic        jtag_tdi_i,         // Test data in
   output logic             cm_we_o,            // Memory write strobe
   input  wire logic        cm_ready_i,         // Memory accepts
   output logic [23:0]      cm_addr_o,          // Memory byte address
   output logic [7:0]       cm_data_o,          // Memory data
   output logic             user_mode_o,        // Load complete
   output logic             cfg_error_o,        // Illegal strap set
   output logic             overrun_o           // Passive byte lost
);

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef struct packed {
      cfl_state_t st;
      logic        rst_s1, rst_s2, rst_d;  // Trigger pin sync and history
      logic [4:0]  low_cnt;               // Low time seen
      logic [1:0]  mode_s1, mode_s2;
      logic [1:0]  wd_s1, wd_s2;
      logic [3:0]  io_s1, io_s2;
      logic        tog_s1, tog_s2, tog_d; // Link byte toggle sync
      cfl_mode_t   mode;                  // Straps caught at start
      cfl_width_t  wd;
      logic [1:0]  div;                   // Flash clock divider
      logic        sclk, cs_n;
      logic [3:0]  oe_n;
      logic [39:0] sh;                    // Outgoing instruction bits
      logic [5:0]  bcnt;
      logic [15:0] wcnt;                  // Wake wait counter
      logic [7:0]  acc;
      logic [3:0]  acnt;
      logic        bv;                    // Byte waiting for FIFO
      logic [7:0]  bdat;
      logic [23:0] nrx;                   // Bytes received
      logic        cm_we;
      logic [23:0] cm_addr;
      logic [7:0]  cm_data;
      logic        done, err, ovr, lk_en;
   } cfl_core_t;

   typedef struct packed {
      logic       rs1, rs2;               // Reset into link domain
      logic       en_s1, en_s2, js_s1, js_s2;
      logic [1:0] wd_s1, wd_s2;
      logic [7:0] acc;
      logic [3:0] acnt;
      logic [7:0] byte_q;                 // Held until next toggle
      logic       tog;
   } cfl_link_t;

   cfl_core_t  s;
   cfl_core_t  next_s;
   cfl_link_t  l;
   cfl_link_t  next_l;
   logic       tick;
   logic       rise;
   logic       f_ready;
   logic       f_valid;
   logic [7:0] f_data;
   logic       f_take;
   logic       f_clear;

   localparam logic [4:0] LOW_MAX = 5'(CFG_RST_LOW_CYC);

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic legal(input cfl_mode_t m, input cfl_width_t w);
      unique case (m)
         MD_ACTIVE:  legal = (w != WD_X8);
         MD_PASSIVE: legal = 1'b1;
         MD_JTAG:    legal = (w == WD_X1);
         MD_BAD:     legal = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] rd_op(input cfl_width_t w);
      unique case (w)
         WD_X2:   rd_op = OP_READ_X2;
         WD_X4:   rd_op = OP_READ_X4;
         default: rd_op = OP_READ_X1;
      endcase
   endfunction

   // Shift in one beat of 1, 2, 4 or 8 bits for w of 0 to 3, first bit most significant
   function automatic logic [7:0] shin(input logic [7:0] a, input logic [7:0] d,
                                      input logic [1:0] w);
      unique case (w)
         2'h0: shin = {a[6:0], d[0]};
         2'h1: shin = {a[5:0], d[1:0]};
         2'h2: shin = {a[3:0], d[3:0]};
         2'h3: shin = d;
      endcase
   endfunction

   // -------------------------------------------------------------
   // Byte buffer
   // -------------------------------------------------------------
   cfl_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .nrst_i      (nrst_i),
      .clear_i     (f_clear),
      .in_valid_i  (s.bv),
      .in_ready_o  (f_ready),
      .in_data_i   (s.bdat),
      .out_valid_o (f_valid),
      .out_ready_i (f_take),
      .out_data_o  (f_data)
   );

   assign tick    = (s.div == SCK_HALF_CYC - 2'h1);
   assign rise    = s.rst_s2 && !s.rst_d;
   assign f_take  = !s.cm_we || cm_ready_i;
   assign f_clear = (s.st == ST_IDLE);

   // -------------------------------------------------------------
   // Core control
   // -------------------------------------------------------------
   always_comb
   begin
      next_s         = s;
      next_s.rst_s1  = config_reset_low_i;
      next_s.rst_s2  = s.rst_s1;
      next_s.rst_d   = s.rst_s2;
      next_s.mode_s1 = mode_sel_i;
      next_s.mode_s2 = s.mode_s1;
      next_s.wd_s1   = width_sel_i;
      next_s.wd_s2   = s.wd_s1;
      next_s.io_s1   = spi_io_i;
      next_s.io_s2   = s.io_s1;
      next_s.tog_s1  = l.tog;
      next_s.tog_s2  = s.tog_s1;
      next_s.tog_d   = s.tog_s2;
      next_s.div     = tick ? 2'h0 : s.div + 2'h1;
      // Low time counts only while the pin is low; a high pin forgets it,
      // so several short pulses cannot add up to one valid low time
      if (!s.rst_s2 && s.low_cnt != LOW_MAX)
         next_s.low_cnt = s.low_cnt + 5'h1;
      else if (s.rst_s2)
         next_s.low_cnt = '0;
      if (s.bv && f_ready)
         next_s.bv = 1'b0;
      // Memory writer drains the FIFO
      if (s.cm_we && cm_ready_i)
      begin
         next_s.cm_we   = 1'b0;
         next_s.cm_addr = s.cm_addr + 24'h1;
      end
      if (f_valid && f_take)
      begin
         next_s.cm_we   = 1'b1;
         next_s.cm_data = f_data;
      end
      unique case (s.st)
         ST_IDLE:
         begin
            if (rise && s.low_cnt == LOW_MAX)
            begin
               next_s.low_cnt = '0;
               next_s.mode    = cfl_mode_t'(s.mode_s2);
               next_s.wd      = cfl_width_t'(s.wd_s2);
               next_s.nrx     = '0;
               next_s.cm_addr = '0;
               next_s.acnt    = '0;
               next_s.err     = 1'b0;
               next_s.ovr     = 1'b0;
               if (!legal(cfl_mode_t'(s.mode_s2), cfl_width_t'(s.wd_s2)))
                  next_s.err = 1'b1;
               else if (s.mode_s2 == MD_ACTIVE)
               begin
                  next_s.st   = ST_WAKE;
                  next_s.sh   = {OP_WAKE, 32'h00000000};
                  next_s.bcnt = WAKE_BITS;
                  next_s.cs_n = 1'b0;
                  next_s.oe_n = 4'hE;
               end
               else
               begin
                  next_s.st    = ST_LINK;
                  next_s.lk_en = 1'b1;
               end
            end
         end
         ST_WAKE, ST_CMD:
         begin
            if (tick && !s.sclk)
               next_s.sclk = 1'b1;
            else if (tick)
            begin
               next_s.sclk = 1'b0;
               next_s.sh   = {s.sh[38:0], 1'b0};
               next_s.bcnt = s.bcnt - 6'h1;
               if (s.bcnt == 6'h1 && s.st == ST_WAKE)
               begin
                  next_s.st   = ST_WAIT;
                  next_s.cs_n = 1'b1;
                  next_s.oe_n = 4'hF;
                  next_s.wcnt = '0;
               end
               else if (s.bcnt == 6'h1)
               begin
                  next_s.st   = ST_DATA;
                  next_s.oe_n = 4'hF;   // Release io0 for wide reads
               end
            end
         end
         ST_WAIT:
         begin
            next_s.wcnt = s.wcnt + 16'h1;
            if (s.wcnt == 16'(WAKE_WAIT - 1))
            begin
               next_s.st   = ST_CMD;
               next_s.sh   = {rd_op(s.wd), START_ADDR, DUMMY_BYTE};
               next_s.bcnt = CMD_BITS;
               next_s.cs_n = 1'b0;
               next_s.oe_n = 4'hE;
            end
         end
         ST_DATA:
         begin
            // Hold the clock low while a byte waits: stalls the flash
            if (tick && !s.sclk && !s.bv)
               next_s.sclk = 1'b1;
            else if (tick && s.sclk)
            begin
               next_s.sclk = 1'b0;
               next_s.acc  = shin(s.acc, (s.wd == WD_X1) ? {7'h0, s.io_s2[1]}
                                                          : {4'h0, s.io_s2}, s.wd);
               next_s.acnt = s.acnt + 4'(4'h1 << s.wd);
               if (next_s.acnt == 4'h8)
               begin
                  next_s.acnt = '0;
                  next_s.bv   = 1'b1;
                  next_s.bdat = next_s.acc;
                  next_s.nrx  = s.nrx + 24'h1;
                  if (s.nrx == 24'(CFG_BYTES - 1))
                  begin
                     next_s.st   = ST_FILL;
                     next_s.cs_n = 1'b1;
                  end
               end
            end
         end
         ST_LINK:
         begin
            if (s.tog_s2 != s.tog_d)
            begin
               if (s.bv)
                  next_s.ovr = 1'b1;   // No way to stall the master
               else
               begin
                  next_s.bv   = 1'b1;
                  next_s.bdat = l.byte_q;
                  next_s.nrx  = s.nrx + 24'h1;
               end
               if (s.nrx == 24'(CFG_BYTES - 1))
               begin
                  next_s.st    = ST_FILL;
                  next_s.lk_en = 1'b0;
               end
            end
         end
         ST_FILL:
         begin
            if (s.cm_addr == 24'(CFG_BYTES) && !s.cm_we && !s.bv && !f_valid)
            begin
               next_s.st   = ST_DONE;
               next_s.done = 1'b1;
            end
         end
         ST_DONE:
            next_s.st = ST_DONE;
      endcase
      // Pin held low again aborts any load
      if (!s.rst_s2 && s.st != ST_IDLE)
      begin
         next_s.st    = ST_IDLE;
         next_s.cs_n  = 1'b1;
         next_s.oe_n  = 4'hF;
         next_s.sclk  = 1'b0;
         next_s.lk_en = 1'b0;
         next_s.done  = 1'b0;
         next_s.bv    = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         s      <= '0;
         s.cs_n <= 1'b1;
         s.oe_n <= 4'hF;
      end
      else
         s <= next_s;
   end

   // -------------------------------------------------------------
   // Link domain: master owns clock, select and data
   // -------------------------------------------------------------
   always_comb
   begin
      next_l       = l;
      next_l.rs1   = nrst_i;
      next_l.rs2   = l.rs1;
      next_l.en_s1 = s.lk_en;
      next_l.en_s2 = l.en_s1;
      next_l.js_s1 = (s.mode == MD_JTAG);
      next_l.js_s2 = l.js_s1;
      next_l.wd_s1 = s.wd;
      next_l.wd_s2 = l.wd_s1;
      if (!l.en_s2)
      begin
         next_l.acc  = '0;
         next_l.acnt = '0;
      end
      else if (!pass_cs_n_i)
      begin
         next_l.acc  = shin(l.acc, l.js_s2 ? {7'h0, jtag_tdi_i} : pass_data_i,
                            l.js_s2 ? 2'h0 : l.wd_s2);
         next_l.acnt = l.acnt + 4'(4'h1 << (l.js_s2 ? 2'h0 : l.wd_s2));
         if (next_l.acnt == 4'h8)
         begin
            next_l.acnt   = '0;
            next_l.byte_q = next_l.acc;
            next_l.tog    = !l.tog;
         end
      end
      if (!l.rs2)
      begin
         next_l     = '0;
         next_l.rs1 = nrst_i;   // Keep sampling so the domain can leave reset
         next_l.rs2 = l.rs1;
      end
   end

   always_ff @(posedge link_clk_i)
   begin
      l <= next_l;
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign spi_sclk_o    = s.sclk;
   assign spi_cs_n_o    = s.cs_n;
   assign spi_io_o      = {3'h0, s.sh[39]};
   assign spi_io_oe_n_o = s.oe_n;
   assign cm_we_o       = s.cm_we;
   assign cm_addr_o     = s.cm_addr;
   assign cm_data_o     = s.cm_data;
   assign user_mode_o   = s.done;
   assign cfg_error_o   = s.err;
   assign overrun_o     = s.ovr;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   load_start_a: assert property ((s.st == ST_IDLE && rise && s.low_cnt == LOW_MAX
      && s.mode_s2 == MD_ACTIVE && s.wd_s2 != WD_X8) |=> !spi_cs_n_o)
      else $error("active load did not start on rising trigger");
   osc_clock_a: assert property (($changed(spi_sclk_o) && s.st != ST_IDLE) |-> $past(tick))
      else $error("flash clock moved off the divider");
   cmd_drive_a: assert property (s.st inside {ST_WAKE, ST_CMD} |->
      !spi_io_oe_n_o[0] && !spi_cs_n_o && spi_io_o[0] == s.sh[39])
      else $error("instruction not driven");
   wake_first_a: assert property ($rose(s.st == ST_WAKE) |->
      s.sh[39:32] == OP_WAKE && s.bcnt == WAKE_BITS)
      else $error("first transaction is not wake");
   wake_wait_a: assert property ((s.st == ST_CMD && $past(s.st) == ST_WAIT) |->
      $past(s.wcnt) == 16'(WAKE_WAIT - 1) && s.sh[31:8] == START_ADDR)
      else $error("wake wait or start address wrong");
   read_op_a: assert property ($rose(s.st == ST_CMD) |->
      s.sh[39:32] == rd_op(s.wd) && s.sh[7:0] == DUMMY_BYTE && s.bcnt == CMD_BITS)
      else $error("read instruction framing wrong");
   width_legal_a: assert property (s.st inside {ST_WAKE, ST_LINK} |->
      legal(s.mode, s.wd))
      else $error("illegal width accepted");
   mode_route_a: assert property (s.st == ST_LINK |-> s.lk_en && spi_cs_n_o)
      else $error("link mode touched the flash");
   done_write_a: assert property ($rose(user_mode_o) |->
      cm_addr_o == 24'(CFG_BYTES) && $past(s.st) == ST_FILL)
      else $error("user mode before memory written");
   stall_clk_a: assert property ((s.st == ST_DATA && s.bv && !f_ready) |=>
      !$rose(spi_sclk_o))
      else $error("flash clocked while buffer full");

   wake_cmd_c: cover property (s.st == ST_WAIT ##1 s.st == ST_CMD);
   done_c:     cover property ($rose(user_mode_o));
   link_c:     cover property (s.st == ST_LINK && s.bv);
   stall_c:    cover property (s.st == ST_DATA && !f_ready);
endmodule

// ### hw/cfl_pkg.sv
// Behaviour
// - Load starts on rising edge after low time.
// - Active mode clocks flash from own oscillator.
// - Active mode drives instruction and address out.
// - First active transaction is flash wake.
// - Wait 30 us, then read from zero.
// - Modes are active, passive and JTAG.
// - Widths: active x1/x2/x4, passive x1-x8, JTAG x1.
// - Bitstream written to configuration memory before user mode.
package cfl_pkg;

   // -------------------------------------------------------------
   // Modes, widths and states
   // -------------------------------------------------------------
   typedef enum logic [1:0] {MD_ACTIVE = 2'b00, MD_PASSIVE = 2'b01,
                             MD_JTAG = 2'b10, MD_BAD = 2'b11} cfl_mode_t;
   typedef enum logic [1:0] {WD_X1 = 2'b00, WD_X2 = 2'b01,
                             WD_X4 = 2'b10, WD_X8 = 2'b11} cfl_width_t;
   typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_WAKE = 3'b001, ST_WAIT = 3'b010,
                             ST_CMD = 3'b011, ST_DATA = 3'b100, ST_LINK = 3'b101,
                             ST_FILL = 3'b110, ST_DONE = 3'b111} cfl_state_t;

   // -------------------------------------------------------------
   // Flash instructions and framing
   // -------------------------------------------------------------
   localparam logic [7:0]  OP_WAKE    = 8'hAB;   // Release from power-down
   localparam logic [7:0]  OP_READ_X1 = 8'h0B;   // Fast read
   localparam logic [7:0]  OP_READ_X2 = 8'h3B;   // Dual-output fast read
   localparam logic [7:0]  OP_READ_X4 = 8'h6B;   // Quad-output fast read
   localparam logic [23:0] START_ADDR = 24'h000000;
   localparam logic [7:0]  DUMMY_BYTE = 8'h00;
   localparam logic [5:0]  WAKE_BITS  = 6'h08;   // Opcode only
   localparam logic [5:0]  CMD_BITS   = 6'h28;   // Opcode, address, dummy

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int REF_CLK_MHZ     = 200;
   localparam int WAKE_WAIT_US    = 30;
   localparam int WAKE_WAIT_CYC   = WAKE_WAIT_US * REF_CLK_MHZ;
   localparam int CFG_RST_LOW_NS  = 100;         // config_reset_low_time
   localparam int CFG_RST_LOW_CYC = (CFG_RST_LOW_NS * REF_CLK_MHZ + 999) / 1000;
   localparam logic [1:0] SCK_HALF_CYC = 2'h2;   // Core cycles per flash clock half
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 32;

endpackage

// ### tb/cfl_flash_model.sv
`timescale 1ns/1ps
// ------------------------------
// Serial flash model
// ------------------------------
module cfl_flash_model (
   input  wire logic       sclk_i,  // Flash clock
   input  wire logic       cs_n_i,  // Select, active low
   input  wire logic       clr_i,   // Forget frames
   input  wire logic       mosi_i,  // Resolved io0
   input  wire logic [1:0] width_i, // Lane code
   output logic [3:0]      io_o,    // Flash data out
   output logic [7:0]      op_o,    // First frame opcode
   output logic [39:0]     cmd_o,   // Read header
   output logic [1:0]      frames_o // Frames ended
);
   logic [39:0] sh;           // Header shift
   logic [7:0]  c;            // Current chunk
   int          rises = 0;    // Rising edges in frame
   int          falls = 0;    // Falling edges in frame
   int          pos   = 0;    // Data bits sent
   function automatic logic [7:0] pat(input int k);
      return 8'h3C + 8'(k) * 8'h11;
   endfunction
   initial io_o = 4'h0;
   initial frames_o = 2'h0;
   // Level clear so a power-up edge on select is not a frame
   always @(clr_i)
      if (clr_i)
      begin
         frames_o = 2'h0;
         pos = 0;
      end
   // Header bits are taken on the rising edge
   always @(posedge sclk_i)
      if (!cs_n_i)
      begin
         if (rises < 40) sh = {sh[38:0], mosi_i};
         rises++;
         if (rises == 40) cmd_o = sh;
      end
   // Data leaves on the falling edge after the header
   always @(negedge sclk_i)
      if (!cs_n_i)
      begin
         falls++;
         if (falls >= 40)
         begin
            c = pat(pos / 8) << (pos % 8);
            c = c >> (8 - (1 << width_i));
            if (width_i == 2'h0) io_o[1] = c[0];
            else io_o = c[3:0];
            pos += 1 << width_i;
         end
      end
   // Deselected lines show no stale value
   always @(posedge cs_n_i)
      if (!clr_i)
      begin
         if (frames_o == 2'h0) op_o = sh[7:0];
         frames_o++;
         rises = 0;
         falls = 0;
         io_o = ~io_o;
      end
endmodule

// ### tb/cfl_loader_tb_top.sv
`timescale 1ns/1ps
`define CHK(a,b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
 $display("BAD %0t compare at line %0d", $time, `__LINE__); end end
// ------------------------------
// Loader bench
// ------------------------------
module cfl_loader_tb_top import cfl_pkg::*;;
   typedef struct packed {logic [1:0] w; logic [7:0] op;} cfl_row_t;
   localparam int NB = 40; // Bytes per load: more than the buffer holds, so a stall fills it
   cfl_row_t    rows [3] = '{'{2'h0, OP_READ_X1}, '{2'h1, OP_READ_X2}, '{2'h2, OP_READ_X4}};
   logic        clk = 0, rst_n = 0, pin = 0, lk = 0, lk_run = 1, hold = 0;
   logic        pcs_n = 1, tdi = 0, rdy = 0, sclk, cs_n, we, um, err, ovr;
   logic [1:0]  mode = 0, wid = 0, frames;
   logic [7:0]  pdat = 0, op, data;
   logic [39:0] cmd;
   logic [3:0]  fio, dio, oe_n;
   logic [23:0] addr;
   int          mismatches = 0, check_count = 0, wr_n = 0, gap = 0, cyc = 0;
   wire  [3:0]  sio = {fio[3:1], oe_n[0] ? fio[0] : dio[0]}; // Resolved lines
   function automatic logic [7:0] pat(input int k);
      return 8'h3C + 8'(k) * 8'h11;
   endfunction
   always #2.5 clk = ~clk;
   // Link clock stands low while the master is quiet
   initial begin #3.3; forever #40 lk = lk_run ? ~lk : 1'b0; end
   cfl_loader #(.WAKE_WAIT(20), .CFG_BYTES(NB)) i_cfl_loader (
      .ref_clk_i(clk), .nrst_i(rst_n), .config_reset_low_i(pin), .mode_sel_i(mode),
      .width_sel_i(wid), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_io_i(sio),
      .spi_io_o(dio), .spi_io_oe_n_o(oe_n), .link_clk_i(lk), .pass_cs_n_i(pcs_n),
      .pass_data_i(pdat), .jtag_tdi_i(tdi), .cm_we_o(we), .cm_ready_i(rdy),
      .cm_addr_o(addr), .cm_data_o(data), .user_mode_o(um), .cfg_error_o(err),
      .overrun_o(ovr));
   cfl_flash_model i_cfl_flash_model (.sclk_i(sclk), .cs_n_i(cs_n), .clr_i(~pin),
      .mosi_i(sio[0]), .width_i(wid), .io_o(fio), .op_o(op), .cmd_o(cmd),
      .frames_o(frames));
   // Stalling memory; every accepted write is checked in order
   always @(posedge clk)
   begin
      cyc++;
      rdy <= #1 (cyc % 3 != 0) && !hold;
      if (cs_n === 1'b1 && frames === 2'h1) gap++;
      if (we === 1'b1 && rdy === 1'b1)
      begin
         `CHK(addr, 24'(wr_n))
         `CHK(data, pat(wr_n))
         wr_n++;
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic start(input logic [1:0] m, input logic [1:0] w, input int low);
      @(posedge clk);
      #1 mode = m;
      wid = w;
      pin = 0;
      repeat (low) @(posedge clk);
      #1 wr_n = 0;
      gap = 0;
      pin = 1;
   endtask
   task automatic wait_um();
      int n;
      n = 0;
      while (um !== 1'b1 && n < 5000) begin @(posedge clk); n++; end
      #1;
      if (n == 5000) begin mismatches++; $display("BAD %0t load hung", $time); summarize(); end
   endtask
   // External master sends NB bytes, first beat most significant
   task automatic link_load(input logic [1:0] m, input logic [1:0] w);
      logic [7:0] c;
      start(m, w, 25);
      lk_run = 1;
      repeat (6) @(posedge lk);
      for (int i = 0; i < NB * 8; i += 1 << w)
      begin
         c = pat(i / 8) << (i % 8);
         #1 pcs_n = 0;
         pdat = c >> (8 - (1 << w));
         tdi = c[7];
         @(posedge lk);
      end
      #1 pcs_n = 1;
      pdat = ~pdat;
      repeat (2) @(posedge lk);
      lk_run = 0;
      wait_um();
      `CHK(wr_n, NB)
      `CHK(ovr, 1'b0)
   endtask
   initial
   begin
      repeat (4) @(posedge lk);
      @(posedge clk);
      #1 rst_n = 1;
      lk_run = 0;
      repeat (4) @(posedge clk);
      #1 `CHK(cs_n, 1'b1)
      `CHK(oe_n, 4'hF)
      for (int r = 0; r < 3; r++)
      begin
         // Quad row holds the memory off until the buffer fills and the flash clock stops
         hold = (r == 2);
         start(2'h0, rows[r].w, 25);
         if (r == 2)
         begin
            repeat (800) @(posedge clk);
            #1 `CHK(cs_n, 1'b0)
            hold = 0;
         end
         wait_um();
         `CHK(op, OP_WAKE)
         `CHK(cmd, {rows[r].op, START_ADDR, DUMMY_BYTE})
         `CHK(gap >= 20, 1'b1)
         `CHK(wr_n, NB)
         `CHK(oe_n, 4'hF)
      end
      // Short low pulses must not start, nor add up to a start; the first aborts user mode
      for (int k = 0; k < 4; k++)
      begin
         start(2'h0, 2'h0, 6);
         for (int i = 0; i < 15; i++) begin @(posedge clk); #1 `CHK(cs_n, 1'b1) end
      end
      `CHK(um, 1'b0)
      // Unsupported strap pairs are refused
      for (int i = 0; i < 3; i++)
      begin
         start(i == 0 ? 2'h3 : 2'(i - 1) * 2'h2, i == 1 ? 2'h3 : 2'h1, 25);
         repeat (50) @(posedge clk);
         #1 `CHK(err, 1'b1)
         `CHK(cs_n, 1'b1)
      end
      for (int w = 0; w < 4; w++) link_load(2'h1, 2'(w));
      link_load(2'h2, 2'h0);
      summarize();
   end
endmodule
